// >>> data_break_block_transfer_tb_top.sv
// Self-checking bench of the break controller and processor model.
// Assumes db_xfer_ctl and db_cpu_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module data_break_block_transfer_tb_top;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic mode3 = 1'b0, ld_count = 1'b0, ld_addr = 1'b0, en_set = 1'b0, dir = 1'b0;
   logic fclr = 1'b0, wrdy = 1'b0, hi = 1'b0;
   logic [11:0] sdata = 12'h000, wdata = 12'h000;
   logic rvalid, breq, dma, add_op, dtm, en, flag, fourth_ts, cend;
   logic [11:0] rdata, addr, dout, doe, word_count, cur_addr, din, sum;
   logic [2:0] field;
   int failures = 0;
   int n_checks = 0;
   db_xfer_ctl i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .mode_three_cycle_i(mode3),
      .setup_data_i(sdata), .load_word_count_i(ld_count), .load_current_address_i(ld_addr),
      .enable_set_i(en_set),
      .dir_to_mem_i(dir), .flag_clear_i(fclr), .word_ready_i(wrdy), .dev_wdata_i(wdata),
      .fourth_time_state_i(fourth_ts), .cycle_end_i(cend), .data_in_i(din), .mem_sum_i(sum),
      .dev_rdata_o(rdata), .dev_rdata_valid_o(rvalid), .break_req_o(breq), .dma_state_o(dma),
      .add_to_memory_op_o(add_op), .dir_to_mem_o(dtm), .addr_o(addr), .field_o(field),
      .data_out_o(dout), .data_oe_o(doe), .enable_o(en), .flag_o(flag),
      .word_count_o(word_count), .current_address_o(cur_addr));
   db_cpu_model i_cpu (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .hi_req_i(hi),
      .dma_state_i(dma), .add_op_i(add_op), .dir_to_mem_i(dtm), .addr_i(addr),
      .data_out_i(dout), .data_oe_i(doe), .fourth_ts_o(fourth_ts), .cycle_end_o(cend),
      .data_in_o(din), .mem_sum_o(sum));
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // Kinds: 0 count, 1 address, 2 enable, 3 word ready, 4 flag clear
   task automatic pulse(input int k, input logic [11:0] v);
      @(posedge mclk_i);
      sdata <= v;
      wdata <= v;
      ld_count <= (k == 0);
      ld_addr <= (k == 1);
      en_set <= (k == 2);
      wrdy <= (k == 3);
      fclr <= (k == 4);
      @(posedge mclk_i);
      {ld_count, ld_addr, en_set, wrdy, fclr} <= 5'h00;
   endtask : pulse
   // Returns once the processor is released after a stolen stretch
   task automatic wait_dma(input logic seen0);
      int i;
      logic seen;
      seen = seen0;
      for (i = 0; i < 300; i++) begin
         @(posedge mclk_i);
         #1;
         if (dma === 1'b1) seen = 1'b1;
         if (seen && dma === 1'b0) break;
      end
      if (i == 300) begin
         failures++;
         stop_test();
      end
   endtask : wait_dma
   initial begin
      int i;
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      #1;
      `CHK("enable", 1'b0, en)
      `CHK("word_count", 12'h000, word_count)
      `CHK("field", 3'h0, field)
      pulse(0, 12'hffe);
      pulse(1, 12'h00f);
      dir <= 1'b1;
      pulse(2, 12'h000);
      pulse(3, 12'h123);
      wait_dma(1'b0);
      `CHK("mem_16", 12'h123, i_cpu.mem[16])
      `CHK("word_count", 12'hfff, word_count)
      `CHK("current_address", 12'h010, cur_addr)
      `CHK("enable", 1'b1, en)
      `CHK("break_req", 1'b0, breq)
      pulse(3, 12'h456);
      wait_dma(1'b0);
      `CHK("mem_17", 12'h456, i_cpu.mem[17])
      `CHK("word_count", 12'h000, word_count)
      `CHK("enable", 1'b0, en)
      `CHK("flag", 1'b1, flag)
      pulse(4, 12'h000);
      #1;
      `CHK("flag", 1'b0, flag)
      i_cpu.mem[48] = 12'hffe;
      i_cpu.mem[49] = 12'h01f;
      i_cpu.mem[32] = 12'habc;
      i_cpu.mem[33] = 12'hdef;
      mode3 <= 1'b1;
      dir <= 1'b0;
      pulse(2, 12'h000);
      pulse(3, 12'h000);
      wait_dma(1'b0);
      `CHK("rdata", 12'habc, rdata)
      `CHK("rdata_valid", 1'b1, rvalid)
      `CHK("mem_48", 12'hfff, i_cpu.mem[48])
      `CHK("mem_49", 12'h020, i_cpu.mem[49])
      `CHK("enable", 1'b1, en)
      pulse(3, 12'h000);
      // Raise the higher line inside the address cycle, so that it yields there
      for (i = 0; i < 200 && !(add_op === 1'b1 && addr === 12'h031); i++) begin
         @(posedge mclk_i);
      end
      if (i == 200) begin
         failures++;
         stop_test();
      end
      hi <= 1'b1;
      wait_dma(1'b1);
      `CHK("break_req", 1'b1, breq)
      `CHK("mem_48", 12'h000, i_cpu.mem[48])
      `CHK("mem_49", 12'h021, i_cpu.mem[49])
      hi <= 1'b0;
      wait_dma(1'b0);
      `CHK("mem_48", 12'h000, i_cpu.mem[48])
      `CHK("rdata", 12'hdef, rdata)
      `CHK("mem_49", 12'h021, i_cpu.mem[49])
      `CHK("enable", 1'b0, en)
      `CHK("flag", 1'b1, flag)
      pulse(4, 12'h000);
      mode3 <= 1'b0;
      dir <= 1'b1;
      pulse(0, 12'hfff);
      pulse(1, 12'h03f);
      pulse(2, 12'h000);
      hi <= 1'b1;
      pulse(3, 12'h5a5);
      repeat (40) @(posedge mclk_i);
      #1;
      `CHK("dma_state", 1'b0, dma)
      `CHK("break_req", 1'b1, breq)
      hi <= 1'b0;
      wait_dma(1'b0);
      `CHK("mem_0", 12'h5a5, i_cpu.mem[0])
      `CHK("flag", 1'b1, flag)
      pulse(3, 12'h111);
      repeat (20) @(posedge mclk_i);
      #1;
      `CHK("break_req", 1'b0, breq)
      // Single-cycle read from memory, word left pending while disabled
      pulse(4, 12'h000);
      i_cpu.mem[1] = 12'h777;
      dir <= 1'b0;
      pulse(1, 12'h000);
      pulse(2, 12'h000);
      wait_dma(1'b0);
      `CHK("rdata", 12'h777, rdata)
      `CHK("rdata_valid", 1'b1, rvalid)
      `CHK("word_count", 12'h001, word_count)
      `CHK("flag", 1'b0, flag)
      `CHK("enable", 1'b1, en)
      stop_test();
   end
endmodule : data_break_block_transfer_tb_top
`default_nettype wire

// >>> db_cfg.svh
// Constants of the data break block transfer controller.
// Assumes inclusion by bare name; definitions only.
`ifndef DB_CFG_SVH
`define DB_CFG_SVH
// Word count location in field 0, even; current address sits one above
`define DB_COUNT_LOC 12'h030
`define DB_ADDR_BIT 12'h001
`define DB_FIELD0 3'h0
// Assigned priority line, 0 highest .. 11 lowest, 12 means no line
`define DB_PRIO_LINE 4'h3
`define DB_ONE 12'h001
`define DB_ZERO 12'h000
`define DB_ALL 12'hfff
`endif

// >>> db_cpu_model.sv
// Processor and memory stand-in facing the break controller.
// Assumes one clock; 64 words of memory, upper address bits ignored.
`timescale 1ns/100ps
`default_nettype none
module db_cpu_model (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic hi_req_i,
   input wire logic dma_state_i,
   input wire logic add_op_i,
   input wire logic dir_to_mem_i,
   input wire logic [11:0] addr_i,
   input wire logic [11:0] data_out_i,
   input wire logic [11:0] data_oe_i,
   output logic fourth_ts_o,
   output logic cycle_end_o,
   output logic [11:0] data_in_o,
   output logic [11:0] mem_sum_o
);
   logic [1:0] cnt;
   logic [11:0] mem [0:63];
   // Four clocks per machine cycle keeps the run short
   assign fourth_ts_o = (cnt == 2'h2);
   assign cycle_end_o = (cnt == 2'h3);
   assign mem_sum_o = mem[addr_i[5:0]] + 12'h001;
   always_comb begin
      data_in_o = (data_out_i & data_oe_i) | (hi_req_i ? 12'h800 : 12'h000);
      if (dma_state_i && !add_op_i && !dir_to_mem_i) begin
         data_in_o = mem[addr_i[5:0]];
      end
   end
   // Plain always: the bench preloads memory through the hierarchy
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
         if (dma_state_i && cycle_end_o && add_op_i) begin
            mem[addr_i[5:0]] <= mem_sum_o;
         end else if (dma_state_i && cycle_end_o && dir_to_mem_i) begin
            mem[addr_i[5:0]] <= data_out_i;
         end
      end
   end
endmodule : db_cpu_model
`default_nettype wire

// >>> db_pkg.sv
// Types shared by the data break block transfer controller.
// Assumes db_cfg.svh holds the numeric constants.
package db_pkg;
   typedef logic [11:0] db_word_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARB,
      ST_XFER1,
      ST_COUNT,
      ST_ADDR,
      ST_DATA
   } db_phase_e;
   typedef struct packed {
      db_phase_e phase;
      db_phase_e resume;
      logic granted;
      logic enable;
      logic flag;
      logic pend;
      logic ovf;
      logic dir;
      logic rvalid;
      db_word_t count;
      db_word_t cur_addr;
      db_word_t bar;
      db_word_t dreg;
      db_word_t rdata;
   } db_state_s;
endpackage : db_pkg

// >>> db_prio_chk.sv
// Break priority check on the shared data lines.
// Assumes data line n is carried on bit 11-n of the data word.
`timescale 1ns/100ps
`default_nettype none
`include "db_cfg.svh"
module db_prio_chk import db_pkg::*; (
   input wire logic [11:0] data_in_i,
   output logic higher_o,
   output logic [11:0] own_bit_o
);
   db_word_t above;

   always_comb begin
      above = `DB_ZERO;
      own_bit_o = `DB_ZERO;
      for (int i = 0; i < 12; i++) begin
         // Line 0 wins; a device with no line sees every line as higher
         above[11-i] = (i < int'(`DB_PRIO_LINE));
         own_bit_o[11-i] = (i == int'(`DB_PRIO_LINE));
      end
      higher_o = |(data_in_i & above);
   end
endmodule : db_prio_chk
`default_nettype wire

// >>> db_xfer_ctl.sv
// Device-side data break controller, single-cycle and three-cycle forms.
// Assumes bus strobes and set-up pulses come from logic on mclk_i.
`timescale 1ns/100ps
`default_nettype none
`include "db_cfg.svh"
module db_xfer_ctl import db_pkg::*; (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic mode_three_cycle_i,
   input wire logic [11:0] setup_data_i,
   input wire logic load_word_count_i,
   input wire logic load_current_address_i,
   input wire logic enable_set_i,
   input wire logic dir_to_mem_i,
   input wire logic flag_clear_i,
   input wire logic word_ready_i,
   input wire logic [11:0] dev_wdata_i,
   input wire logic fourth_time_state_i,
   input wire logic cycle_end_i,
   input wire logic [11:0] data_in_i,
   input wire logic [11:0] mem_sum_i,
   output logic [11:0] dev_rdata_o,
   output logic dev_rdata_valid_o,
   output logic break_req_o,
   output logic dma_state_o,
   output logic add_to_memory_op_o,
   output logic dir_to_mem_o,
   output logic [11:0] addr_o,
   output logic [2:0] field_o,
   output logic [11:0] data_out_o,
   output logic [11:0] data_oe_o,
   output logic enable_o,
   output logic flag_o,
   output logic [11:0] word_count_o,
   output logic [11:0] current_address_o
);
   db_state_s s;
   db_state_s next_s;
   logic higher;
   logic [11:0] own_bit;

   function automatic db_word_t inc_word(input db_word_t w);
      return w + `DB_ONE;
   endfunction : inc_word

   db_prio_chk u_prio (
      .data_in_i(data_in_i),
      .higher_o(higher),
      .own_bit_o(own_bit)
   );

   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      if (flag_clear_i) begin
         next_s.flag = 1'b0;
      end
      if (load_word_count_i) begin
         next_s.count = setup_data_i;
      end
      if (load_current_address_i) begin
         next_s.cur_addr = setup_data_i;
      end
      if (enable_set_i) begin
         next_s.enable = 1'b1;
         next_s.ovf = 1'b0;
         next_s.dir = dir_to_mem_i;
      end
      unique case (s.phase)
         ST_IDLE: begin
            if (s.enable && s.pend) begin
               next_s.phase = ST_ARB;
               next_s.resume = mode_three_cycle_i ? ST_COUNT : ST_XFER1;
            end
         end
         ST_ARB: begin
            if (fourth_time_state_i && !higher) begin
               next_s.granted = 1'b1;
            end
            if (cycle_end_i) begin
               next_s.granted = 1'b0;
               // Lost arbitration simply retries in the following cycle
               if (s.granted || (fourth_time_state_i && !higher)) begin
                  next_s.phase = s.resume;
               end
            end
         end
         ST_XFER1: begin
            if (cycle_end_i) begin
               next_s.count = inc_word(s.count);
               next_s.cur_addr = inc_word(s.cur_addr);
               next_s.pend = 1'b0;
               next_s.rdata = s.dir ? s.rdata : data_in_i;
               next_s.rvalid = !s.dir;
               next_s.phase = ST_IDLE;
               if (inc_word(s.count) == `DB_ZERO) begin
                  next_s.enable = 1'b0;
                  next_s.flag = 1'b1;
               end
            end
         end
         ST_COUNT: begin
            if (cycle_end_i) begin
               next_s.ovf = (mem_sum_i == `DB_ZERO);
               next_s.resume = ST_ADDR;
               next_s.phase = higher ? ST_ARB : ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (cycle_end_i) begin
               next_s.bar = mem_sum_i;
               next_s.resume = ST_DATA;
               next_s.phase = higher ? ST_ARB : ST_DATA;
            end
         end
         ST_DATA: begin
            if (cycle_end_i) begin
               next_s.pend = 1'b0;
               next_s.rdata = s.dir ? s.rdata : data_in_i;
               next_s.rvalid = !s.dir;
               next_s.phase = ST_IDLE;
               if (s.ovf) begin
                  next_s.enable = 1'b0;
                  next_s.flag = 1'b1;
                  next_s.ovf = 1'b0;
               end
            end
         end
      endcase
      // A new word wins over the clear of the one just moved
      if (word_ready_i) begin
         next_s.pend = 1'b1;
         next_s.dreg = dev_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      addr_o = `DB_ZERO;
      data_out_o = `DB_ZERO;
      data_oe_o = `DB_ZERO;
      unique case (s.phase)
         ST_IDLE: begin
         end
         ST_ARB: begin
            data_out_o = own_bit;
            data_oe_o = own_bit;
         end
         ST_XFER1: begin
            addr_o = inc_word(s.cur_addr);
            data_out_o = s.dir ? s.dreg : `DB_ZERO;
            data_oe_o = s.dir ? `DB_ALL : `DB_ZERO;
         end
         ST_COUNT: begin
            addr_o = `DB_COUNT_LOC;
            data_out_o = `DB_ONE;
            data_oe_o = `DB_ALL;
         end
         ST_ADDR: begin
            addr_o = `DB_COUNT_LOC | `DB_ADDR_BIT;
            data_out_o = `DB_ONE;
            data_oe_o = `DB_ALL;
         end
         ST_DATA: begin
            addr_o = s.bar;
            data_out_o = s.dir ? s.dreg : `DB_ZERO;
            data_oe_o = s.dir ? `DB_ALL : `DB_ZERO;
         end
      endcase
   end

   assign break_req_o = (s.phase == ST_ARB);
   assign dma_state_o = (s.phase == ST_XFER1) || (s.phase == ST_COUNT) ||
                        (s.phase == ST_ADDR) || (s.phase == ST_DATA);
   assign add_to_memory_op_o = (s.phase == ST_COUNT) || (s.phase == ST_ADDR);
   assign dir_to_mem_o = s.dir && ((s.phase == ST_XFER1) || (s.phase == ST_DATA));
   assign field_o = `DB_FIELD0;
   assign enable_o = s.enable;
   assign flag_o = s.flag;
   assign word_count_o = s.count;
   assign current_address_o = s.cur_addr;
   assign dev_rdata_o = s.rdata;
   assign dev_rdata_valid_o = s.rvalid;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   chk_single_one_cycle: assert property (
      (s.phase == ST_XFER1) && cycle_end_i |=> !dma_state_o)
      else $error("single-cycle break held longer than one cycle");
   chk_count_addr_step: assert property (
      (s.phase == ST_XFER1) && cycle_end_i && !load_word_count_i && !load_current_address_i |=>
      (word_count_o == inc_word($past(s.count))) &&
      (current_address_o == inc_word($past(s.cur_addr))))
      else $error("count or address not stepped in transfer cycle");
   chk_stay_enabled: assert property (
      (s.phase == ST_XFER1) && cycle_end_i && (inc_word(s.count) != `DB_ZERO) |=>
      enable_o && (s.phase == ST_IDLE))
      else $error("device not released while still enabled");
   chk_three_order: assert property (
      (s.phase == ST_COUNT) && cycle_end_i && !higher |=>
      (s.phase == ST_ADDR) && add_to_memory_op_o)
      else $error("address cycle does not follow count cycle");
   chk_loc_pair: assert property (
      (s.phase == ST_ADDR) |-> ((addr_o & ~`DB_ADDR_BIT) == `DB_COUNT_LOC) && addr_o[0])
      else $error("address location not paired with count location");
   chk_yield_resume: assert property (
      (s.phase == ST_ADDR) && cycle_end_i && higher |=> break_req_o && (s.resume == ST_DATA))
      else $error("yield did not keep resume point");
   chk_ovf_exit: assert property (
      (s.phase == ST_XFER1) && cycle_end_i && (s.count == `DB_ALL) && !enable_set_i |=>
      flag_o && !enable_o)
      else $error("overflow did not clear enable and set flag");
   chk_add_one: assert property (
      (s.phase == ST_COUNT) |-> add_to_memory_op_o && (data_out_o == `DB_ONE) &&
      (data_oe_o == `DB_ALL) && (addr_o == `DB_COUNT_LOC))
      else $error("count cycle does not add one at its location");
   chk_bar_load: assert property (
      (s.phase == ST_ADDR) && cycle_end_i && !higher |=>
      (s.phase == ST_DATA) && (addr_o == $past(mem_sum_i)))
      else $error("break address not taken from incremented value");
   chk_grant_take: assert property (
      (break_req_o && fourth_time_state_i && !higher) ##[1:3] cycle_end_i |=> dma_state_o)
      else $error("granted request did not take next cycle");
   chk_data_flag: assert property (
      (s.phase == ST_DATA) && cycle_end_i && s.ovf && !enable_set_i |=> flag_o && !enable_o)
      else $error("three-cycle overflow did not end block");
endmodule : db_xfer_ctl
`default_nettype wire
